// ### verilog/cascade_link_consts.vh
`ifndef CASCADE_LINK_CONSTS_VH
`define CASCADE_LINK_CONSTS_VH

// Reference clock rate and time-to-cycle conversion (least times round up).
`define REF_CLK_MHZ 10
`define CYC_UP(ns) ((((ns) * `REF_CLK_MHZ + 999) / 1000 < 1) ? 1 : (((ns) * `REF_CLK_MHZ + 999) / 1000))

// Link word layout.
`define WORD_W 40
`define DATA_W 36
`define ADDR_W 4
`define FIFO_DEPTH 16
`define FIFO_PTR_W 4

// First nonvolatile configuration word.
`define CFG_W 36
`define CFG_FB_LSB 3
`define CFG_FB_W 5
`define CFG_MODE_LSB 8
`define CFG_MODE_W 2
`define CFG_LAT_LSB 10
`define CFG_LAT_W 4
`define CFG_RESET 36'h000003C00

// Link timing modes.
`define MODE_FIELD_0 2'h0
`define MODE_FIELD_1 2'h1
`define MODE_OUT_0 2'h0
`define MODE_OUT_1 2'h1
`define MODE_OUT_2 2'h2

// Forwarded data delay after the trigger edge, in ns.
`define FWD_M0_NS 30
`define FWD_M1_NS 50
`define FWD_M2_NS 30

// Least latch delay per code, in ns.
`define LAT_C00_NS 300
`define LAT_C01_NS 600
`define LAT_C02_NS 1300
`define LAT_C03_NS 2600
`define LAT_C04_NS 5300
`define LAT_C05_NS 10000
`define LAT_C06_NS 21000
`define LAT_C07_NS 42000
`define LAT_C08_NS 85000
`define LAT_C09_NS 170000
`define LAT_C10_NS 341000
`define LAT_C11_NS 682000
`define LAT_C12_NS 1365000
`define LAT_C13_NS 2730000
`define LAT_C14_NS 5461000
`define LAT_C15_NS 10922000
`define LAT_CNT_W 24

// Least spacing after a latch before the next rising edge, in oscillator periods.
`define LATCH_GAP_CYC 2

// Feedback target voltage mapping, in millivolts.
`define FB_BASE_MV 7000
`define FB_SPAN_MV 10000
`define FB_STEPS 31
`define FB_MV_W 15

`endif

// ### verilog/word_fifo.v
`timescale 1ns/1ps
`include "cascade_link_consts.vh"

module word_fifo #(
  parameter WIDTH = `WORD_W,
  parameter DEPTH = `FIFO_DEPTH,
  parameter PTR_W = `FIFO_PTR_W
) (
  // Clock and reset.
  input wire i_ref_clk,
  input wire i_rst_n,
  // Filling side.
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  // Draining side.
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_ff;
  reg [PTR_W-1:0] rd_ptr_ff;
  reg [PTR_W:0] count_ff;
  reg [PTR_W:0] nxt_count;
  reg full_ff;
  reg valid_ff;
  wire push;
  wire pop;

  assign o_in_ready = ~full_ff;
  assign o_out_valid = valid_ff;
  assign o_out_data = mem[rd_ptr_ff];
  assign push = i_in_valid & ~full_ff;
  assign pop = i_out_ready & valid_ff;

  always @*
  begin
    nxt_count = count_ff;
    if (push & ~pop)
      nxt_count = count_ff + 1'b1;
    else if (pop & ~push)
      nxt_count = count_ff - 1'b1;
  end

  always @(posedge i_ref_clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= i_in_data;
  end

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_ff <= {PTR_W{1'b0}};
      rd_ptr_ff <= {PTR_W{1'b0}};
      count_ff <= {(PTR_W+1){1'b0}};
      full_ff <= 1'b0;
      valid_ff <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == DEPTH - 1) ? {PTR_W{1'b0}} : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == DEPTH - 1) ? {PTR_W{1'b0}} : rd_ptr_ff + 1'b1;
      count_ff <= nxt_count;
      full_ff <= (nxt_count == DEPTH);
      valid_ff <= (nxt_count != {(PTR_W+1){1'b0}});
    end
  end

endmodule

// ### verilog/fb_target_map.v
`timescale 1ns/1ps
`include "cascade_link_consts.vh"

module fb_target_map (
  // Clock and reset.
  input wire i_ref_clk,
  input wire i_rst_n,
  // Code in, target out.
  input wire [`CFG_FB_W-1:0] i_code,
  output reg [`FB_MV_W-1:0] o_target_mv
);

  localparam [`FB_MV_W-1:0] BASE_MV = `FB_BASE_MV;

  integer mv;

  // Millivolts are base plus ten volts times code over thirty-one, truncated.
  always @*
  begin
    mv = `FB_BASE_MV + (`FB_SPAN_MV * i_code) / `FB_STEPS;
  end

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_target_mv <= BASE_MV;
    else
      o_target_mv <= mv[`FB_MV_W-1:0];
  end

endmodule

// ### verilog/cascade_link_timing.v
// Function
// - The two-bit timing-mode field selects mode 0 for 00, mode 1 for 01 and mode 2 for both 10 and 11.
// - In mode 0 the forwarded clock follows the level of the incoming clock.
// - In mode 0 the forwarded data changes shortly after a falling edge of the incoming clock.
// - In mode 1 the forwarded data changes about 50 ns after a rising edge of the incoming clock.
// - In mode 2 the forwarded data changes about 30 ns after a rising edge of the incoming clock.
// - After the programmed delay from the last rising edge, the low 36 bits go to the latch named by the top 4.
// - A 4-bit code picks the latch delay, roughly doubling per step from 0.3 us to 10922 us at least.
// - The 5-bit feedback code maps to 7.0 V plus ten thirty-firsts of a volt per step, up to 17.0 V.
// - The timing-mode field sits in bits 9 to 8 of the first configuration word, default zero.
// - The latch delay code sits in bits 13 to 10 of the first configuration word, default all ones.
// - The feedback code sits in bits 7 to 3 of the first configuration word, default zero.
`timescale 1ns/1ps
`include "cascade_link_consts.vh"

module cascade_link_timing #(
  parameter DLY_C11_CYC = `CYC_UP(`LAT_C11_NS),
  parameter DLY_C12_CYC = `CYC_UP(`LAT_C12_NS),
  parameter DLY_C13_CYC = `CYC_UP(`LAT_C13_NS),
  parameter DLY_C14_CYC = `CYC_UP(`LAT_C14_NS),
  parameter DLY_C15_CYC = `CYC_UP(`LAT_C15_NS)
) (
  // Clock and reset.
  input wire i_ref_clk,
  input wire i_rst_n,
  // Configuration word.
  input wire [`CFG_W-1:0] i_cfg_word,
  input wire i_cfg_load,
  // Incoming link.
  input wire i_clock_in_pair,
  input wire i_data_in_pair,
  // Forwarded link.
  output wire o_clock_out_pair,
  output wire o_data_out_pair,
  // Latched words.
  output wire o_word_valid,
  input wire i_word_ready,
  output wire [`ADDR_W-1:0] o_word_addr,
  output wire [`DATA_W-1:0] o_word_data,
  // Status.
  output wire [1:0] o_link_mode,
  output wire o_latch_pending,
  output wire o_gap_violation,
  output wire [`FB_MV_W-1:0] o_feedback_target_voltage
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_PUSH = 3'h4;
  localparam [`LAT_CNT_W-1:0] ONE_CNT = 24'h000001;
  localparam [`LAT_CNT_W-1:0] ZERO_CNT = 24'h000000;
  localparam [3:0] ZERO_FWD = 4'h0;
  localparam [1:0] GAP_CYC = `LATCH_GAP_CYC;

  function [`LAT_CNT_W-1:0] lat_cycles;
    input [`CFG_LAT_W-1:0] code;
    integer c;
    begin
      case (code)
        4'h0: c = `CYC_UP(`LAT_C00_NS);
        4'h1: c = `CYC_UP(`LAT_C01_NS);
        4'h2: c = `CYC_UP(`LAT_C02_NS);
        4'h3: c = `CYC_UP(`LAT_C03_NS);
        4'h4: c = `CYC_UP(`LAT_C04_NS);
        4'h5: c = `CYC_UP(`LAT_C05_NS);
        4'h6: c = `CYC_UP(`LAT_C06_NS);
        4'h7: c = `CYC_UP(`LAT_C07_NS);
        4'h8: c = `CYC_UP(`LAT_C08_NS);
        4'h9: c = `CYC_UP(`LAT_C09_NS);
        4'hA: c = `CYC_UP(`LAT_C10_NS);
        4'hB: c = DLY_C11_CYC;
        4'hC: c = DLY_C12_CYC;
        4'hD: c = DLY_C13_CYC;
        4'hE: c = DLY_C14_CYC;
        default: c = DLY_C15_CYC;
      endcase
      lat_cycles = c[`LAT_CNT_W-1:0];
    end
  endfunction

  function [3:0] fwd_cycles;
    input [1:0] mode;
    integer c;
    begin
      case (mode)
        `MODE_OUT_0: c = `CYC_UP(`FWD_M0_NS);
        `MODE_OUT_1: c = `CYC_UP(`FWD_M1_NS);
        default: c = `CYC_UP(`FWD_M2_NS);
      endcase
      fwd_cycles = c[3:0];
    end
  endfunction

  reg [`CFG_W-1:0] cfg_ff;
  reg [1:0] mode_ff;
  reg clk_s1_ff;
  reg clk_s2_ff;
  reg clk_s3_ff;
  reg dat_s1_ff;
  reg dat_s2_ff;
  reg [`WORD_W-1:0] shreg_ff;
  reg fwd_bit_ff;
  reg [3:0] fwd_cnt_ff;
  reg clk_out_ff;
  reg dat_out_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [`LAT_CNT_W-1:0] lat_cnt_ff;
  reg [1:0] gap_cnt_ff;
  reg gap_err_ff;
  reg [`ADDR_W-1:0] word_addr_ff;
  reg [`DATA_W-1:0] word_data_ff;
  reg word_valid_ff;
  reg pending_ff;
  wire rise;
  wire fall;
  wire fwd_trigger;
  wire [1:0] mode_field;
  wire [`CFG_LAT_W-1:0] lat_code;
  wire [`CFG_FB_W-1:0] fb_code;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`WORD_W-1:0] fifo_out_data;
  wire push;

  assign mode_field = cfg_ff[`CFG_MODE_LSB +: `CFG_MODE_W];
  assign lat_code = cfg_ff[`CFG_LAT_LSB +: `CFG_LAT_W];
  assign fb_code = cfg_ff[`CFG_FB_LSB +: `CFG_FB_W];

  assign rise = clk_s2_ff & ~clk_s3_ff;
  assign fall = ~clk_s2_ff & clk_s3_ff;
  assign fwd_trigger = (mode_ff == `MODE_OUT_0) ? fall : rise;
  assign push = (state_ff == ST_PUSH) & fifo_in_ready;

  assign o_clock_out_pair = clk_out_ff;
  assign o_data_out_pair = dat_out_ff;
  assign o_link_mode = mode_ff;
  assign o_latch_pending = pending_ff;
  assign o_gap_violation = gap_err_ff;

  // The factory default word loads at reset; a new word loads on request.
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_ff <= `CFG_RESET;
      mode_ff <= `MODE_OUT_0;
    end
    else
    begin
      if (i_cfg_load)
        cfg_ff <= i_cfg_word;
      case (mode_field)
        `MODE_FIELD_0: mode_ff <= `MODE_OUT_0;
        `MODE_FIELD_1: mode_ff <= `MODE_OUT_1;
        default: mode_ff <= `MODE_OUT_2;
      endcase
    end
  end

  // Link pins are synchronised before any edge detection.
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      dat_s1_ff <= 1'b0;
      dat_s2_ff <= 1'b0;
    end
    else
    begin
      clk_s1_ff <= i_clock_in_pair;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      dat_s1_ff <= i_data_in_pair;
      dat_s2_ff <= dat_s1_ff;
    end
  end

  // The bit leaving the top of the shift register is the one passed down the chain.
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      shreg_ff <= {`WORD_W{1'b0}};
      fwd_bit_ff <= 1'b0;
    end
    else if (rise)
    begin
      shreg_ff <= {shreg_ff[`WORD_W-2:0], dat_s2_ff};
      fwd_bit_ff <= shreg_ff[`WORD_W-1];
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_out_ff <= 1'b0;
      dat_out_ff <= 1'b0;
      fwd_cnt_ff <= ZERO_FWD;
    end
    else
    begin
      clk_out_ff <= clk_s2_ff;
      if (fwd_trigger)
        fwd_cnt_ff <= fwd_cycles(mode_ff);
      else if (fwd_cnt_ff != ZERO_FWD)
        fwd_cnt_ff <= fwd_cnt_ff - 1'b1;
      if (fwd_cnt_ff == 4'h1)
        dat_out_ff <= (mode_ff == `MODE_OUT_0) ? shreg_ff[`WORD_W-1] : fwd_bit_ff;
    end
  end

  // Latch sequencer: every rising edge restarts the delay; a full buffer stalls the latch.
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (rise)
          nxt_state = ST_WAIT;
      ST_WAIT:
        if (!rise && lat_cnt_ff == ONE_CNT)
          nxt_state = ST_PUSH;
      ST_PUSH:
        if (rise)
          nxt_state = ST_WAIT;
        else if (fifo_in_ready)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_IDLE;
      pending_ff <= 1'b0;
      lat_cnt_ff <= ZERO_CNT;
      gap_cnt_ff <= 2'h0;
      gap_err_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pending_ff <= (nxt_state != ST_IDLE);
      if (rise)
        lat_cnt_ff <= lat_cycles(lat_code);
      else if (lat_cnt_ff != ZERO_CNT)
        lat_cnt_ff <= lat_cnt_ff - 1'b1;
      if (push && !rise)
        gap_cnt_ff <= GAP_CYC;
      else if (gap_cnt_ff != 2'h0)
        gap_cnt_ff <= gap_cnt_ff - 1'b1;
      gap_err_ff <= rise & (gap_cnt_ff != 2'h0);
    end
  end

  word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH),
    .PTR_W(`FIFO_PTR_W)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push & ~rise),
    .o_in_ready(fifo_in_ready),
    .i_in_data(shreg_ff),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_word_ready | ~word_valid_ff),
    .o_out_data(fifo_out_data)
  );

  // Output stage keeps the latched word on flip-flops.
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      word_valid_ff <= 1'b0;
      word_addr_ff <= {`ADDR_W{1'b0}};
      word_data_ff <= {`DATA_W{1'b0}};
    end
    else if (i_word_ready || !word_valid_ff)
    begin
      word_valid_ff <= fifo_out_valid;
      word_addr_ff <= fifo_out_data[`WORD_W-1:`DATA_W];
      word_data_ff <= fifo_out_data[`DATA_W-1:0];
    end
  end

  assign o_word_valid = word_valid_ff;
  assign o_word_addr = word_addr_ff;
  assign o_word_data = word_data_ff;

  fb_target_map u_fb_map (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_code(fb_code),
    .o_target_mv(o_feedback_target_voltage)
  );

endmodule

// ### bench/link_host_model.sv
`timescale 1ns/1ps
module link_host_model (
  // Link lines toward the block.
  output logic o_link_clk,
  output logic o_link_dat
);
  initial
  begin
    o_link_clk = 1'b0;
    o_link_dat = 1'b0;
  end

  // Sends one word MSB first at 800 ns per bit; the clock rests low between frames.
  task automatic send_word(input logic [39:0] w, input int gap_ns);
    #(gap_ns);
    for (int i = 39; i >= 0; i--)
    begin
      o_link_dat = w[i];
      #400;
      o_link_clk = 1'b1;
      #400;
      o_link_clk = 1'b0;
    end
    // The data line shows no stale value once a frame is over.
    o_link_dat = ~w[0];
  endtask
endmodule

// ### bench/cascade_link_timing_chk.sv
`timescale 1ns/1ps
module cascade_link_timing_chk #(
  parameter DLY_C11_CYC = 32'h1AA4,
  parameter DLY_C12_CYC = 32'h3552,
  parameter DLY_C13_CYC = 32'h6AA4,
  parameter DLY_C14_CYC = 32'hD552,
  parameter DLY_C15_CYC = 32'h1AAA4
) (
  // Clock, reset and configuration.
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [35:0] i_cfg_word,
  input wire i_cfg_load,
  // Link and latched words.
  input wire i_clock_in_pair,
  input wire i_word_ready,
  input wire o_clock_out_pair,
  input wire o_data_out_pair,
  input wire o_word_valid,
  input wire [3:0] o_word_addr,
  input wire [35:0] o_word_data,
  // Status.
  input wire [1:0] o_link_mode,
  input wire o_latch_pending,
  input wire o_gap_violation,
  input wire [14:0] o_feedback_target_voltage
);
  reg [3:0] code_ff;
  reg [17:0] quiet_ff;
  reg clk_prev_ff;

  function automatic [1:0] dec_mode(input [1:0] f);
    dec_mode = (f == 2'h0) ? 2'h0 : (f == 2'h1) ? 2'h1 : 2'h2;
  endfunction

  function automatic [17:0] min_cyc(input [3:0] c);
    case (c)
      4'h0: min_cyc = 18'h3;
      4'h1: min_cyc = 18'h6;
      4'h2: min_cyc = 18'hD;
      4'h3: min_cyc = 18'h1A;
      4'h4: min_cyc = 18'h35;
      4'h5: min_cyc = 18'h64;
      4'h6: min_cyc = 18'hD2;
      4'h7: min_cyc = 18'h1A4;
      4'h8: min_cyc = 18'h352;
      4'h9: min_cyc = 18'h6A4;
      4'hA: min_cyc = 18'hD52;
      4'hB: min_cyc = DLY_C11_CYC[17:0];
      4'hC: min_cyc = DLY_C12_CYC[17:0];
      4'hD: min_cyc = DLY_C13_CYC[17:0];
      4'hE: min_cyc = DLY_C14_CYC[17:0];
      default: min_cyc = DLY_C15_CYC[17:0];
    endcase
  endfunction

  // Tracks the latch code in force and the quiet time since the last forwarded rising edge.
  always @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      code_ff <= 4'hF;
      quiet_ff <= 18'h0;
      clk_prev_ff <= 1'b0;
    end
    else
    begin
      if (i_cfg_load)
        code_ff <= i_cfg_word[13:10];
      clk_prev_ff <= o_clock_out_pair;
      quiet_ff <= (o_clock_out_pair && !clk_prev_ff) ? 18'h0 : quiet_ff + {17'h0, ~&quiet_ff};
    end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  mode_load_a: assert property (i_cfg_load |=> ##1 o_link_mode == dec_mode($past(i_cfg_word[9:8], 2)))
    else $error("link mode not decoded from loaded field");
  fb_map_a: assert property (i_cfg_load ##1 !i_cfg_load |=>
    o_feedback_target_voltage == 15'h1B58 + 15'((32'h2710 * $past(i_cfg_word[7:3], 2)) / 32'h1F))
    else $error("feedback target does not match code");
  clock_fwd_a: assert property (o_clock_out_pair == $past(i_clock_in_pair, 3))
    else $error("forwarded clock does not follow incoming clock");
  data_phase_a: assert property ($changed(o_data_out_pair) |-> o_clock_out_pair == (o_link_mode != 2'h0))
    else $error("forwarded data changed in wrong clock phase");
  gap_pulse_a: assert property (o_gap_violation |=> !o_gap_violation)
    else $error("gap flag longer than one cycle");
  latch_time_a: assert property ($fell(o_latch_pending) |-> quiet_ff >= min_cyc(code_ff))
    else $error("word latched before programmed delay");
  latch_start_a: assert property ($rose(o_clock_out_pair) |-> ##[0:2] o_latch_pending)
    else $error("latch delay not started by rising edge");
  word_hold_a: assert property (o_word_valid && !i_word_ready |=>
    o_word_valid && $stable(o_word_data) && $stable(o_word_addr))
    else $error("latched word dropped before accepted");
endmodule

bind cascade_link_timing cascade_link_timing_chk #(
  .DLY_C11_CYC(DLY_C11_CYC),
  .DLY_C12_CYC(DLY_C12_CYC),
  .DLY_C13_CYC(DLY_C13_CYC),
  .DLY_C14_CYC(DLY_C14_CYC),
  .DLY_C15_CYC(DLY_C15_CYC)
) u_chk (
  .i_ref_clk, .i_rst_n, .i_cfg_word, .i_cfg_load, .i_clock_in_pair, .i_word_ready,
  .o_clock_out_pair, .o_data_out_pair, .o_word_valid, .o_word_addr, .o_word_data,
  .o_link_mode, .o_latch_pending, .o_gap_violation, .o_feedback_target_voltage
);

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_ref_clk, i_rst_n, i_cfg_load, i_word_ready, clk_line, dat_line;
  logic [35:0] i_cfg_word;
  logic [39:0] exp_q[$];
  logic [31:0] rng_state;
  int failures, total_checks, gap_seen;
  wire o_clock_out_pair, o_data_out_pair, o_word_valid, o_latch_pending, o_gap_violation;
  wire [3:0] o_word_addr;
  wire [35:0] o_word_data;
  wire [1:0] o_link_mode;
  wire [14:0] o_feedback_target_voltage;

  link_host_model host (.o_link_clk(clk_line), .o_link_dat(dat_line));

  cascade_link_timing #(.DLY_C11_CYC(20), .DLY_C12_CYC(20), .DLY_C13_CYC(20), .DLY_C14_CYC(20),
    .DLY_C15_CYC(20)) dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg_word(i_cfg_word), .i_cfg_load(i_cfg_load),
    .i_clock_in_pair(clk_line), .i_data_in_pair(dat_line), .o_clock_out_pair(o_clock_out_pair),
    .o_data_out_pair(o_data_out_pair), .o_word_valid(o_word_valid), .i_word_ready(i_word_ready),
    .o_word_addr(o_word_addr), .o_word_data(o_word_data), .o_link_mode(o_link_mode),
    .o_latch_pending(o_latch_pending), .o_gap_violation(o_gap_violation),
    .o_feedback_target_voltage(o_feedback_target_voltage)
  );

  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk)
    if (o_gap_violation === 1'b1)
      gap_seen++;

  function automatic logic [31:0] xorshift();
    rng_state ^= rng_state << 13;
    rng_state ^= rng_state >> 17;
    rng_state ^= rng_state << 5;
    return rng_state;
  endfunction

  function automatic logic [14:0] fb_mv(input logic [4:0] c);
    return 15'h1B58 + 15'((32'h2710 * c) / 32'h1F);
  endfunction

  function automatic logic [1:0] mode_of(input logic [1:0] f);
    return (f == 2'h0) ? 2'h0 : (f == 2'h1) ? 2'h1 : 2'h2;
  endfunction

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic load_cfg(input logic [1:0] m, input logic [3:0] lat, input logic [4:0] fb);
    @(posedge i_ref_clk);
    #1;
    i_cfg_word = {22'h0, lat, m, fb, 3'h0};
    i_cfg_load = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_cfg_load = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic send(input int gap);
    logic [31:0] r1, r2;
    r1 = xorshift();
    r2 = xorshift();
    exp_q.push_back({r1[7:0], r2});
    @(posedge i_ref_clk);
    #1;
    host.send_word({r1[7:0], r2}, gap);
  endtask

  // Accepts words under random back-pressure and compares them in order.
  task automatic drain();
    logic [31:0] r;
    for (int k = 0; k < 5000 && exp_q.size() > 0; k++)
    begin
      @(posedge i_ref_clk);
      if (o_word_valid === 1'b1 && i_word_ready === 1'b1)
        check({o_word_addr, o_word_data}, exp_q.pop_front());
      #1;
      r = xorshift();
      i_word_ready = r[0];
    end
    i_word_ready = 1'b0;
    if (exp_q.size() > 0)
    begin
      failures++;
      tally_and_finish();
    end
  endtask

  initial
  begin
    logic [31:0] r;
    logic [4:0] c;
    int n;
    i_rst_n = 1'b0;
    i_cfg_load = 1'b0;
    i_cfg_word = 36'h0;
    i_word_ready = 1'b0;
    rng_state = 32'h14EBB;
    failures = 0;
    total_checks = 0;
    gap_seen = 0;
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    @(posedge i_ref_clk);
    #1;
    check(o_link_mode, 2'h0);
    check(o_feedback_target_voltage, 15'h1B58);
    send(1000);
    repeat (14) @(posedge i_ref_clk);
    #1;
    check(o_latch_pending, 1'b1);
    drain();
    for (int m = 0; m < 4; m++)
    begin
      load_cfg(m[1:0], 4'h2, 5'h0);
      check(o_link_mode, mode_of(m[1:0]));
      send(5000);
      send(5000);
      repeat (10) @(posedge i_ref_clk);
      #1;
      // Mode 0 passes on the first bit of the new word; modes 1 and 2 the last bit of the word before.
      check(o_data_out_pair, (m == 0) ? exp_q[exp_q.size()-1][39] : exp_q[exp_q.size()-2][0]);
      drain();
    end
    for (int k = 0; k < 8; k++)
    begin
      r = xorshift();
      c = (k == 0) ? 5'h0 : (k == 1) ? 5'h1F : r[4:0];
      load_cfg(2'h2, 4'h2, c);
      check(o_feedback_target_voltage, fb_mv(c));
    end
    // Fill the buffer until a latch stalls, then drain it.
    n = 0;
    while (n < 24 && o_latch_pending !== 1'b1)
    begin
      send(3000);
      n++;
      repeat (30) @(posedge i_ref_clk);
      #1;
    end
    check(n >= 16 && o_latch_pending === 1'b1, 1'b1);
    drain();
    check(gap_seen, 0);
    load_cfg(2'h1, 4'h2, 5'h0);
    send(5000);
    for (int g = 600; g <= 1100; g += 100)
      send(g);
    drain();
    check(gap_seen >= 1 && gap_seen <= 2, 1'b1);
    tally_and_finish();
  end
endmodule
